/* include/sfd_params.svh */
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH

// ****************************************
// serial register map
// ****************************************
`define SFD_NOP_ADDR      6'h00
`define SFD_CFG_ADDR      6'h1b
`define SFD_WARN_ADDR     6'h26
`define SFD_WARN_FE_BIT   11
`define SFD_WARN_CRC_BIT  10
`define SFD_WARN_FIXED    4'hb
`define SFD_CFG_S17_BIT   1
`define SFD_CFG_CRCEN_BIT 0
`define SFD_CFG_RESET     8'h00
// write-one-clear positions inside the high warning byte
`define SFD_CLR_FE_BIT    3
`define SFD_CLR_CRC_BIT   2

// ****************************************
// frame lengths in serial clocks
// ****************************************
`define SFD_LEN16 5'd16
`define SFD_LEN17 5'd17
`define SFD_LEN20 5'd20
`define SFD_LEN21 5'd21

// ****************************************
// crc and timing
// ****************************************
`define SFD_CRC_POLY      4'h3
`define SFD_CRC_SEED      4'hb
`define SFD_CORE_NS       50
`define SFD_STRAY_WIN_NS  70
`define SFD_STRAY_WIN_CYC ((`SFD_STRAY_WIN_NS + `SFD_CORE_NS - 1) / `SFD_CORE_NS)

`endif

/* include/sfd_pkg.sv */
`include "sfd_params.svh"

package sfd_pkg;

  // ****************************************
  // types
  // ****************************************
  // frame summary handed from the serial clock side
  typedef struct packed {
    logic [4:0]  cnt;
    logic [1:0]  strays;
    logic [20:0] bits;
  } sfd_frame_s;

  typedef enum logic {SFD_IDLE, SFD_HOLD} sfd_state_e;

  // crc over a 16-bit word, msb first
  function automatic logic [3:0] sfd_crc4(input logic [15:0] d);
    logic [3:0] c;
    logic       fb;
    c = `SFD_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c  = {c[2:0], 1'b0} ^ (fb ? `SFD_CRC_POLY : 4'h0);
    end
    return c;
  endfunction : sfd_crc4

endpackage : sfd_pkg

/* hw/sfd_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// two-flop level synchroniser
// ****************************************
module sfd_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // level in and out
  input  wire logic d,
  output logic      q
);

  logic meta_reg;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      q        <= 1'b1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sfd_sync

`default_nettype wire

/* hw/sfd_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_params.svh"

// ****************************************
// serial clock side: edge counting and shifting
// ****************************************
module sfd_link (
  // link
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe,
  // reset
  input  wire logic              nrst,
  // core side, quasi-static while chip select is low
  input  wire logic [15:0]       resp_word,
  output sfd_pkg::sfd_frame_s    frame
);

  logic       frame_rst_n;
  logic [4:0] cnt_reg;
  logic [4:0] last_reg;
  logic [1:0] stray_reg;
  logic [1:0] taken_reg;
  logic [20:0] sr_reg;
  logic [3:0] crc;

  assign frame_rst_n = nrst & ~cs_n;
  assign crc         = sfd_pkg::sfd_crc4(resp_word);

  // falling edges inside the frame, cleared by chip select high
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_reg <= 5'h00;
    end else if (cnt_reg != 5'h1f) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // response bit out on each falling edge
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso <= 1'b0;
    end else if (cnt_reg < 5'd16) begin
      miso <= resp_word[4'hf - cnt_reg[3:0]];
    end else if (cnt_reg < `SFD_LEN20) begin
      miso <= crc[2'h3 - cnt_reg[1:0]];
    end else begin
      miso <= crc[3];
    end
  end

  // final count of the last frame survives chip select high
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= 5'h00;
    end else if (!cs_n) begin
      last_reg <= (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
    end
  end

  // edges while deselected, handed to the next frame
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      stray_reg <= 2'h0;
      taken_reg <= 2'h0;
    end else if (cs_n) begin
      if (last_reg != `SFD_LEN21 && stray_reg != 2'h3) begin
        stray_reg <= stray_reg + 2'h1;
      end
    end else if (cnt_reg == 5'h00) begin
      taken_reg <= stray_reg;
      stray_reg <= 2'h0;
    end
  end

  // mosi sampled on rising edges of the frame
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      sr_reg <= 21'h000000;
    end else if (!cs_n) begin
      sr_reg <= {sr_reg[19:0], mosi};
    end
  end

  assign miso_oe = ~cs_n;
  assign frame   = '{cnt: last_reg, strays: taken_reg, bits: sr_reg};

  // ****************************************
  // checks
  // ****************************************
  stray_ignored_a : assert property (@(negedge sclk) disable iff (!nrst)
    (cs_n && last_reg == `SFD_LEN21) |=> stray_reg == $past(stray_reg))
    else $error("stray edge counted after a 21-bit frame");
  stray_counted_a : assert property (@(negedge sclk) disable iff (!nrst)
    (cs_n && last_reg != `SFD_LEN21 && stray_reg != 2'h3) |=> stray_reg == $past(stray_reg) + 2'h1)
    else $error("stray edge not counted while deselected");
  crc_repeat_a : assert property (@(posedge sclk) disable iff (!nrst)
    (!cs_n && cnt_reg == `SFD_LEN21) |-> miso == crc[3])
    else $error("21st bit is not the crc msb");

endmodule : sfd_link

`default_nettype wire

/* hw/sfd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_params.svh"


// ****************************************
// frame error detector top
// ****************************************
module sfd_top (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // spi link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  // sensor status flags, core domain
  input  wire logic [8:0] status_flags,
  // observation
  output logic            frame_error_flag,
  output logic            crc_error_flag,
  output logic            seventeen_bit_frame_select
);

  localparam int WIN = `SFD_STRAY_WIN_CYC;

  sfd_pkg::sfd_frame_s frame;
  sfd_pkg::sfd_state_e st_reg;
  logic        cs_s;
  logic        cs_d_reg;
  logic        rise;
  logic [1:0]  win_reg;
  logic        commit;
  logic [7:0]  cfg_reg;
  logic [15:0] resp_reg;
  logic        first_reg;
  logic        crc_en;
  logic [4:0]  n;
  logic [1:0]  s;
  logic        legal_n;
  logic        cnt_ok;
  logic [15:0] hdr;
  logic [3:0]  crc_rx;
  logic        lead;
  logic        rw;
  logic [5:0]  addr;
  logic [7:0]  data;
  logic        crc_bad;
  logic        fe_set;
  logic        crc_set;
  logic        exec;
  logic        wr_warn;
  logic        fe_clr;
  logic        crc_clr;
  logic [15:0] warn_word;

  // ****************************************
  // serial clock domain
  // ****************************************
  sfd_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .miso      (miso),
    .miso_oe   (miso_oe),
    .nrst      (nrst),
    .resp_word (resp_reg),
    .frame     (frame)
  );

  // chip select into the core clock
  sfd_sync u_cs_sync (
    .clk  (core_clk),
    .nrst (nrst),
    .d    (cs_n),
    .q    (cs_s)
  );

  // ****************************************
  // frame end detection
  // ****************************************
  // delayed copy for edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_d_reg <= 1'b1;
    end else begin
      cs_d_reg <= cs_s;
    end
  end

  assign rise = cs_s & ~cs_d_reg;

  // hold off past the stray window before judging the frame
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg  <= sfd_pkg::SFD_IDLE;
      win_reg <= 2'h0;
    end else begin
      unique case (st_reg)
        sfd_pkg::SFD_IDLE: begin
          win_reg <= 2'h0;
          if (rise) begin
            st_reg <= sfd_pkg::SFD_HOLD;
          end
        end
        sfd_pkg::SFD_HOLD: begin
          win_reg <= win_reg + 2'h1;
          if (!cs_s || commit) begin
            st_reg <= sfd_pkg::SFD_IDLE;
          end
        end
      endcase
    end
  end

  // one-cycle judgement pulse, after frame data has settled
  assign commit = (st_reg == sfd_pkg::SFD_HOLD) && cs_s && (win_reg == 2'(WIN - 1));

  // ****************************************
  // frame decode
  // ****************************************
  assign n       = frame.cnt;
  assign s       = frame.strays;
  assign crc_en  = cfg_reg[`SFD_CFG_CRCEN_BIT];
  assign seventeen_bit_frame_select = cfg_reg[`SFD_CFG_S17_BIT];

  // accepted own lengths
  assign legal_n = (n == `SFD_LEN16) || (seventeen_bit_frame_select && n == `SFD_LEN17) ||
                   (n == `SFD_LEN20) || (n == `SFD_LEN21);

  // strays carried in from the deselected period
  assign cnt_ok  = legal_n && ((s == 2'h0) ||
                   (seventeen_bit_frame_select && n == `SFD_LEN16 && s == 2'h1));

  // header sits above any crc and trailing bit
  assign hdr     = 16'(frame.bits >> (n - `SFD_LEN16));
  assign crc_rx  = 4'(frame.bits >> (n - `SFD_LEN20));
  assign lead    = hdr[15];
  assign rw      = hdr[14];
  assign addr    = hdr[13:8];
  assign data    = hdr[7:0];
  assign crc_bad = crc_en && (n >= `SFD_LEN20) && (sfd_pkg::sfd_crc4(hdr) != crc_rx);

  assign fe_set  = commit && (!cnt_ok || lead);
  assign crc_set = commit && (crc_bad || (crc_en && first_reg && s != 2'h0));
  assign exec    = commit && legal_n && !lead && !crc_bad;
  assign wr_warn = exec && rw && (addr == `SFD_WARN_ADDR);
  assign fe_clr  = wr_warn && data[`SFD_CLR_FE_BIT];
  assign crc_clr = wr_warn && data[`SFD_CLR_CRC_BIT];

  // ****************************************
  // registers
  // ****************************************
  // read-only warning word
  assign warn_word = {`SFD_WARN_FIXED, frame_error_flag, crc_error_flag, 1'b0, status_flags};

  // register contents by word address, address bit 0 ignored
  function automatic logic [15:0] read_word(input logic [5:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a[5:1] == 5'(`SFD_WARN_ADDR >> 1)) begin
      w = warn_word;
    end else if (a[5:1] == 5'(`SFD_CFG_ADDR >> 1)) begin
      w = {8'h00, cfg_reg};
    end
    return w;
  endfunction : read_word

  // configuration byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= `SFD_CFG_RESET;
    end else if (exec && rw && addr == `SFD_CFG_ADDR) begin
      cfg_reg <= data;
    end
  end

  // pipelined read response, held if a frame is dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resp_reg <= 16'h0000;
    end else if (exec && !rw) begin
      resp_reg <= read_word(addr);
    end
  end

  // marks the first judged frame since reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      first_reg <= 1'b1;
    end else if (commit) begin
      first_reg <= 1'b0;
    end
  end

  // frame error flag, set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_error_flag <= 1'b0;
    end else if (fe_set) begin
      frame_error_flag <= 1'b1;
    end else if (fe_clr) begin
      frame_error_flag <= 1'b0;
    end
  end

  // crc error flag, set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc_error_flag <= 1'b0;
    end else if (crc_set) begin
      crc_error_flag <= 1'b1;
    end else if (crc_clr) begin
      crc_error_flag <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  fe_on_count_a : assert property ((commit && !cnt_ok) |=> frame_error_flag)
    else $error("bad count did not set frame error");
  fe_on_lead_a : assert property ((commit && lead) |=> frame_error_flag && $past(!exec))
    else $error("leading one did not set frame error");
  warn_fixed_a : assert property (warn_word[15:12] == 4'hb && !warn_word[9] &&
    warn_word[11] == frame_error_flag && warn_word[10] == crc_error_flag)
    else $error("warning word layout broken");
  s17off_stray_a : assert property ((commit && !seventeen_bit_frame_select && s != 2'h0)
    |=> frame_error_flag)
    else $error("stray with option clear not flagged");
  s17_one_ok_a : assert property ((commit && seventeen_bit_frame_select && n == `SFD_LEN16
    && s == 2'h1 && !lead && !frame_error_flag && !crc_bad) |=> !frame_error_flag)
    else $error("single tolerated stray flagged");
  s17_frame_a : assert property ((commit && seventeen_bit_frame_select && n == `SFD_LEN17
    && s != 2'h0) |=> frame_error_flag)
    else $error("17-bit stray not flagged");
  judge_delay_a : assert property ((rise ##1 cs_s [*2]) |-> commit)
    else $error("frame not judged after hold-off");
  cfg_write_a : assert property ((exec && rw && addr == `SFD_CFG_ADDR)
    |=> seventeen_bit_frame_select == $past(data[`SFD_CFG_S17_BIT]))
    else $error("config write lost");
  nop_zero_a : assert property ((exec && !rw && addr == `SFD_NOP_ADDR) |=> resp_reg == 16'h0000)
    else $error("no-op read not zero");
  poweron_crc_a : assert property ((commit && crc_en && first_reg && s != 2'h0)
    |=> crc_error_flag && frame_error_flag)
    else $error("power-on stray did not set crc error");

  // flag clears, refusals and one judgement per frame
  fe_clear_a : assert property ((fe_clr && !fe_set) |=> !frame_error_flag)
    else $error("frame error clear lost");
  crc_clear_a : assert property ((crc_clr && !crc_set) |=> !crc_error_flag)
    else $error("crc error clear lost");
  resp_hold_a : assert property (!(exec && !rw) |=> $stable(resp_reg))
    else $error("response changed without a read");
  len_refuse_a : assert property ((commit && !legal_n) |=> $stable(cfg_reg) && $stable(resp_reg))
    else $error("bad-length frame executed");
  lead_refuse_a : assert property ((commit && lead) |=> $stable(cfg_reg))
    else $error("frame with leading one executed");
  judge_once_a : assert property (commit |=> !commit)
    else $error("frame judged twice");
  first_once_a : assert property (commit |=> !first_reg)
    else $error("power-on mark not cleared");

  bad_frame_c : cover property (commit && !cnt_ok);
  stray_ok_c  : cover property (commit && cnt_ok && s == 2'h1);
  write_c     : cover property (exec && rw);
  long_frame_c : cover property (commit && n == `SFD_LEN21 && cnt_ok);
  crc_err_c   : cover property (crc_set);

endmodule : sfd_top

`default_nettype wire

/* tb/sfd_master.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// spi master model, link clock 6 ns, idle high
// ****************************************
module sfd_master (
  // link
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // idle: clock parked high, device deselected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame of len clocks, msb first, miso taken at each rising edge
  task automatic frame(input int len, input logic [20:0] w, output logic [31:0] got);
    got = '0;
    #1.3;
    cs_n = 1'b0;
    #3;
    for (int k = 0; k < len; k++) begin
      sclk = 1'b0;
      mosi = (k < 21) ? w[20-k] : 1'b0;
      #3;
      got  = {got[30:0], miso};
      sclk = 1'b1;
      #3;
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale level
  endtask : frame

  // clock low pulses while deselected, as on a shared clock line
  task automatic stray(input int n);
    repeat (n) begin
      sclk = 1'b0;
      #3;
      sclk = 1'b1;
      #3;
    end
  endtask : stray
endmodule : sfd_master

`default_nettype wire

/* tb/sfd_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfd_params.svh"

// ****************************************
// frame error detector bench
// ****************************************
module sfd_top_tb_top;
  logic        core_clk, nrst, sclk, cs_n, mosi, miso, miso_oe;
  logic [8:0]  status_flags;
  logic        fe, crc, sel;
  logic [31:0] seed;
  int          error_cnt, check_count;
  // model state
  logic        m_fe, m_crc, m_first, m_prev21;
  logic [7:0]  m_cfg;
  logic [15:0] m_resp;

  sfd_top uut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .status_flags(status_flags), .frame_error_flag(fe), .crc_error_flag(crc),
    .seventeen_bit_frame_select(sel));
  sfd_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // core clock, 50 ns
  always #25 core_clk = ~core_clk;

  // xorshift source for status bits
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // reference crc, msb first
  function automatic logic [3:0] ref_crc(input logic [15:0] d);
    logic [3:0] c;
    c = `SFD_CRC_SEED;
    for (int i = 15; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? `SFD_CRC_POLY : 4'h0);
    return c;
  endfunction : ref_crc

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_flag

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  // reset pulse of two cycles, model back to power-on
  task automatic do_reset;
    nrst = 1'b0;
    {m_fe, m_crc, m_prev21, m_cfg, m_resp} = '0;
    m_first = 1'b1;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_flag(fe, 1'b0);
    chk_flag(sel, 1'b0);
  endtask : do_reset

  // strays, one frame, commit wait, model step, compare all results
  task automatic xfer(input int len, input logic [15:0] h, input int ns);
    logic [20:0] w;
    logic [31:0] got, exp;
    logic [3:0]  c;
    int          st;
    logic        ok, serr, wr;
    w = {h, ref_crc(h), 1'b0};
    @(negedge core_clk);
    seed = xs(seed);
    status_flags <= seed[8:0];
    m.stray(ns);
    @(negedge core_clk);
    m.frame(len, w, got);
    c = ref_crc(m_resp);
    exp = '0;
    for (int k = 0; k < len; k++) exp = {exp[30:0], k < 16 ? m_resp[15-k] : (k < 20 ? c[19-k] : c[3])};
    chk_word(got, exp);
    if (len == 20 || len == 21) chk_word({28'h0, ref_crc(got[len-1 -: 16])}, {28'h0, got[len-17 -: 4]});
    repeat (14) @(negedge core_clk);
    st   = (m_prev21 && !m_first) ? 0 : (ns > 3 ? 3 : ns);
    serr = st != 0 && !(m_cfg[1] && len == 16 && st == 1);
    ok   = (len == 16 || len == 20 || len == 21 || (len == 17 && m_cfg[1])) && !h[15];
    wr   = ok && h[14];
    if (!ok || serr || m_first) m_fe = 1'b1;
    else if (wr && h[13:8] == `SFD_WARN_ADDR && h[3]) m_fe = 1'b0;
    if (wr && h[13:8] == `SFD_WARN_ADDR && h[2]) m_crc = 1'b0;
    if (wr && h[13:8] == `SFD_CFG_ADDR) m_cfg = h[7:0];
    if (ok && !h[14]) begin
      if (h[13:8] == `SFD_WARN_ADDR) m_resp = {`SFD_WARN_FIXED, m_fe, m_crc, 1'b0, seed[8:0]};
      else if (h[13:8] == `SFD_CFG_ADDR) m_resp = {8'h00, m_cfg};
      else m_resp = 16'h0000;
    end
    m_first  = 1'b0;
    m_prev21 = (len == 21);
    chk_flag(fe, m_fe);
    chk_flag(crc, m_crc);
    chk_flag(sel, m_cfg[1]);
  endtask : xfer

  localparam logic [15:0] NOP   = {2'b00, `SFD_NOP_ADDR, 8'h00};
  localparam logic [15:0] RDW   = {2'b00, `SFD_WARN_ADDR, 8'h5a};
  localparam logic [15:0] RDC   = {2'b00, `SFD_CFG_ADDR, 8'h00};
  localparam logic [15:0] CLR   = {2'b01, `SFD_WARN_ADDR, 8'h0c};
  localparam logic [15:0] S17   = {2'b01, `SFD_CFG_ADDR, 8'h02};
  localparam logic [15:0] CRCON = {2'b01, `SFD_CFG_ADDR, 8'h03};
  int lens [7] = '{15, 16, 17, 18, 20, 21, 22};

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    status_flags = '0;
    seed = 32'hb879;
    error_cnt = 0;
    check_count = 0;
    do_reset();
    xfer(16, NOP, 2);
    xfer(16, CLR, 0);
    // lengths 15 to 22 except 19, read warning word, then clear
    for (int i = 0; i < 7; i++) begin
      xfer(lens[i], RDW, 0);
      xfer(16, CLR, 0);
    end
    xfer(16, NOP, 0);
    xfer(16, S17 | 16'h8000, 0);
    xfer(16, CLR, 0);
    xfer(16, NOP, 1);
    xfer(16, CLR, 0);
    xfer(16, S17, 0);
    xfer(16, NOP, 2);
    xfer(16, CLR, 0);
    xfer(16, NOP, 1);
    xfer(17, NOP, 1);
    xfer(17, CLR, 0);
    xfer(20, RDC, 1);
    xfer(20, CLR, 0);
    xfer(21, RDW, 0);
    xfer(21, NOP, 3);
    xfer(20, CRCON, 0);
    xfer(20, RDC, 0);
    xfer(21, NOP, 0);
    do_reset();
    xfer(21, NOP, 1);
    xfer(21, CLR, 0);
    xfer(21, NOP, 2);
    complete_run();
  end
endmodule : sfd_top_tb_top

`default_nettype wire
